// ### core/bmb_boot_map.sv
`include "bmb_map.svh"
module bmb_boot_map #(
    parameter int WAIT_W = 4
) (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic        transfer_start_n_i,
    input  wire logic [31:0] addr_i,
    input  wire logic        ext_ack_n_i,
    input  wire logic        mask_write_i,
    input  wire logic [31:0] mask_base_i,
    input  wire logic        boot_half_jumper_i,
    input  wire logic        cfg_write_i,
    input  wire logic [3:0]  cfg_data_i,
    output logic             boot_select_n_o,
    output logic             transfer_ack_n_o,
    output logic             transfer_ack_oe_o,
    output logic             cycle_busy_o,
    output logic [31:0]      flash_addr_o,
    output logic [3:0]       helper_mux_cfg_bits_o,
    output logic [3:0]       helper_mux_led_on_o
);
    bmb_pkg::bmb_state_t state;
    bmb_pkg::bmb_state_t next_state;
    logic              configured;
    logic              next_configured;
    logic [31:0]       base;
    logic [31:0]       next_base;
    logic [3:0]        cfg;
    logic [3:0]        next_cfg;
    logic [WAIT_W-1:0] waits;
    logic [WAIT_W-1:0] next_waits;
    logic              jp_s1;
    logic              jp_s2;
    logic              jp_s3;
    logic              jp_stable;
    logic              next_jp_s1;
    logic              next_jp_s2;
    logic              next_jp_s3;
    logic              next_jp_stable;
    logic              ext_s1;
    logic              ext_s2;
    logic              ext_s3;
    logic              ext_ack;
    logic              ext_ack_prev;
    logic              next_ext_s1;
    logic              next_ext_s2;
    logic              next_ext_s3;
    logic              next_ext_ack;
    logic              next_ext_ack_prev;
    logic              ext_ack_rise;
    logic              sel;
    logic              ack;
    logic              take;
    logic              next_boot_select_n;
    logic              next_transfer_ack_n;
    logic              next_transfer_ack_oe;
    logic              next_cycle_busy;
    logic [31:0]       next_flash_addr;
    logic [3:0]        next_cfg_bits;
    logic [3:0]        next_led_on;

    // Second and third stage must agree, so a one-cycle glitch never counts
    function automatic logic settle(input logic s2, input logic s3, input logic held);
        return (s2 == s3) ? s3 : held;
    endfunction

    function automatic logic flash_hit(input logic [31:0] a, input logic [31:0] b);
        return ((a & `BMB_FLASH_MASK) == b);
    endfunction

    // Low byte vector fetches fold onto flash start, upper half when jumpered
    function automatic logic [31:0] flash_offset(input logic [31:0] a, input logic upper);
        logic [31:0] o;
        o = a & ~`BMB_FLASH_MASK;
        if (upper) begin
            o = o | (`BMB_FLASH_UPPER - `BMB_FLASH_BASE);
        end
        return o;
    endfunction

    always_comb begin
        next_jp_s1     = boot_half_jumper_i;
        next_jp_s2     = jp_s1;
        next_jp_s3     = jp_s2;
        next_jp_stable = settle(jp_s2, jp_s3, jp_stable);
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            jp_s1     <= 1'b0;
            jp_s2     <= 1'b0;
            jp_s3     <= 1'b0;
            jp_stable <= 1'b0;
        end else begin
            jp_s1     <= next_jp_s1;
            jp_s2     <= next_jp_s2;
            jp_s3     <= next_jp_s3;
            jp_stable <= next_jp_stable;
        end
    end

    always_comb begin
        next_ext_s1       = ext_ack_n_i;
        next_ext_s2       = ext_s1;
        next_ext_s3       = ext_s2;
        next_ext_ack      = settle(!ext_s2, !ext_s3, ext_ack);
        next_ext_ack_prev = ext_ack;
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            ext_s1       <= 1'b1;
            ext_s2       <= 1'b1;
            ext_s3       <= 1'b1;
            ext_ack      <= 1'b0;
            ext_ack_prev <= 1'b0;
        end else begin
            ext_s1       <= next_ext_s1;
            ext_s2       <= next_ext_s2;
            ext_s3       <= next_ext_s3;
            ext_ack      <= next_ext_ack;
            ext_ack_prev <= next_ext_ack_prev;
        end
    end

    always_comb begin
        next_configured = configured || mask_write_i;
        next_base       = mask_write_i ? mask_base_i : base;
        next_cfg        = cfg_write_i ? cfg_data_i : cfg;
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            configured <= 1'b0;
            base       <= `BMB_FLASH_BASE;
            cfg        <= `BMB_CFG_RESET;
        end else begin
            configured <= next_configured;
            base       <= next_base;
            cfg        <= next_cfg;
        end
    end

    // Unconfigured decode hits everything so flash serves the vectors
    always_comb begin
        sel          = !configured || flash_hit(addr_i, base);
        take         = !transfer_start_n_i && (state == bmb_pkg::BMB_IDLE);
        // Only a fresh edge ends a board-acknowledged cycle; a board still holding the line low is stale
        ext_ack_rise = ext_ack && !ext_ack_prev;
        ack          = 1'b0;
        next_state   = state;
        next_waits   = waits;
        case (state)
            bmb_pkg::BMB_IDLE: begin
                if (!transfer_start_n_i) begin
                    next_waits = WAIT_W'(`BMB_BOOT_WAITS);
                    next_state = sel ? bmb_pkg::BMB_WAIT : bmb_pkg::BMB_ACK;
                end
            end
            bmb_pkg::BMB_WAIT: begin
                if (waits == '0) begin
                    ack        = 1'b1;
                    next_state = bmb_pkg::BMB_IDLE;
                end else begin
                    next_waits = waits - WAIT_W'(1);
                end
            end
            bmb_pkg::BMB_ACK: begin
                // No internal ack here: hold until a board answers
                if (ext_ack_rise) begin
                    next_state = bmb_pkg::BMB_IDLE;
                end
            end
            default: next_state = bmb_pkg::BMB_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state <= bmb_pkg::BMB_IDLE;
            waits <= '0;
        end else begin
            state <= next_state;
            waits <= next_waits;
        end
    end

    always_comb begin
        next_boot_select_n   = !(next_state == bmb_pkg::BMB_WAIT);
        next_transfer_ack_n  = !ack;
        next_transfer_ack_oe = ack;
        next_cycle_busy      = (next_state != bmb_pkg::BMB_IDLE);
        next_flash_addr      = flash_addr_o;
        if (take) begin
            next_flash_addr = `BMB_FLASH_BASE | flash_offset(addr_i, jp_stable);
        end
        next_cfg_bits        = next_cfg;
        // Indicator lit means jumper off, hence the inverse
        next_led_on          = ~next_cfg;
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            boot_select_n_o       <= 1'b1;
            transfer_ack_n_o      <= 1'b1;
            transfer_ack_oe_o     <= 1'b0;
            cycle_busy_o          <= 1'b0;
            flash_addr_o          <= '0;
            helper_mux_cfg_bits_o <= `BMB_CFG_RESET;
            helper_mux_led_on_o   <= ~`BMB_CFG_RESET;
        end else begin
            boot_select_n_o       <= next_boot_select_n;
            transfer_ack_n_o      <= next_transfer_ack_n;
            transfer_ack_oe_o     <= next_transfer_ack_oe;
            cycle_busy_o          <= next_cycle_busy;
            flash_addr_o          <= next_flash_addr;
            helper_mux_cfg_bits_o <= next_cfg_bits;
            helper_mux_led_on_o   <= next_led_on;
        end
    end
endmodule // bmb_boot_map

// ### core/bmb_map.svh
`ifndef BMB_MAP_SVH
`define BMB_MAP_SVH
// Function
// - After reset the processor fetches its stack pointer and program counter from the first 8 bytes.
// - Until the mask register is written, the boot select answers every access at any address.
// - A cycle starts with transfer start and ends only when transfer acknowledge arrives.
// - A region may be set to raise acknowledge internally after a set number of wait states.
// - The boot select auto-acknowledges each flash access after six wait states.
// - Once configured, the flash is decoded from base 7FE00000 instead of zero.
// - With the boot-half jumper in its alternate position, booting uses the upper half at 7FF00000.
// - Four configuration bits drive the SDRAM helper mux; a lit indicator means jumper off.
`define BMB_VECTOR_BYTES    32'h0000_0008
`define BMB_FLASH_BASE      32'h7FE0_0000
`define BMB_FLASH_UPPER     32'h7FF0_0000
`define BMB_FLASH_MASK      32'hFFE0_0000
`define BMB_BOOT_WAITS      4'h6
`define BMB_CFG_RESET       4'h0
`endif

// ### core/bmb_pkg.sv
package bmb_pkg;
    typedef enum logic [2:0] {
        BMB_IDLE = 3'b001,
        BMB_WAIT = 3'b010,
        BMB_ACK  = 3'b100
    } bmb_state_t;
endpackage

// ### verif/bmb_boot_map_checker.sv
module bmb_boot_map_checker (
    input wire logic       mclk_i, reset_n_i, transfer_start_n_i, cycle_busy_o,
    input wire logic       boot_select_n_o, transfer_ack_n_o, transfer_ack_oe_o,
    input wire logic [3:0] helper_mux_cfg_bits_o, helper_mux_led_on_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    sequence take; !transfer_start_n_i && !cycle_busy_o; endsequence
    chk_six_waits: assert property (take ##1 !boot_select_n_o |-> ##7 !transfer_ack_n_o)
        else $error("late ack");
    chk_select_span: assert property (take ##1 !boot_select_n_o |->
        (!boot_select_n_o && transfer_ack_n_o)[*7] ##1 boot_select_n_o) else $error("select span");
    chk_ack_pulse: assert property (!transfer_ack_n_o |=> transfer_ack_n_o) else $error("ack");
    chk_ack_ends: assert property (!transfer_ack_n_o |-> transfer_ack_oe_o &&
        $fell(cycle_busy_o)) else $error("ack no end");
    chk_busy_take: assert property (take |=> cycle_busy_o) else $error("not taken");
    chk_idle_quiet: assert property (!cycle_busy_o |-> boot_select_n_o) else $error("sel");
    chk_oe_low: assert property (transfer_ack_oe_o |-> !transfer_ack_n_o) else $error("oe");
    chk_led_inverse: assert property (helper_mux_led_on_o == ~helper_mux_cfg_bits_o)
        else $error("led");
    cover property (take ##1 !boot_select_n_o);
    cover property ($fell(cycle_busy_o) && transfer_ack_n_o);
    cover property (!transfer_ack_n_o);
endmodule // bmb_boot_map_checker
bind bmb_boot_map bmb_boot_map_checker bmb_boot_map_checker_inst (.mclk_i, .reset_n_i,
    .transfer_start_n_i, .cycle_busy_o, .boot_select_n_o, .transfer_ack_n_o,
    .transfer_ack_oe_o, .helper_mux_cfg_bits_o, .helper_mux_led_on_o);

// ### verif/bmb_board.sv
module bmb_board (
    input wire logic       clk_i, start_n_i, busy_i, on_i,
    input wire logic [3:0] wait_i,
    output logic           pull_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 0;
    logic       live = 0;
    initial pull_o = 0;
    // Pulls low only; the line returns high through the base board pull-up
    always @(posedge clk_i) begin
        if (!start_n_i && !busy_i && on_i) begin live <= 1; cnt <= wait_i; end
        else if (live && cnt != 0) cnt <= cnt - 4'h1;
        pull_o <= live && cnt == 0 && busy_i;
        if (pull_o && !busy_i) live <= 0;
    end
endmodule // bmb_board

// ### verif/tb_bmb_boot_map.sv
module tb_bmb_boot_map;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, reset_n_i = 0, ts_n = 1, mw = 0, jp = 0, cw = 0, on = 0, pull, sel_n;
    logic ack_n, oe, busy;
    logic [31:0] addr = 0, fa;
    logic [3:0] cd = 0, wt = 0, cb, led;
    int err_total = 0, n_compared = 0, cyc_n = 0;
    // Wired-low acknowledge shared by the block and the board
    wire ack_line = !(pull || (oe && !ack_n));
    initial forever #2 mclk_i = ~mclk_i;
    bmb_boot_map bmb_boot_map_inst (.mclk_i, .reset_n_i, .transfer_start_n_i(ts_n),
        .addr_i(addr), .ext_ack_n_i(ack_line), .mask_write_i(mw), .mask_base_i(32'h7FE0_0000),
        .boot_half_jumper_i(jp), .cfg_write_i(cw), .cfg_data_i(cd), .boot_select_n_o(sel_n),
        .transfer_ack_n_o(ack_n), .transfer_ack_oe_o(oe), .cycle_busy_o(busy),
        .flash_addr_o(fa), .helper_mux_cfg_bits_o(cb), .helper_mux_led_on_o(led));
    bmb_board bmb_board_inst (.clk_i(mclk_i), .start_n_i(ts_n), .busy_i(busy), .on_i(on),
        .wait_i(wt), .pull_o(pull));
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic go(input logic [31:0] a, output int n, output logic s);
        @(negedge mclk_i); ts_n = 0; addr = a; n = 1; s = 0;
        @(negedge mclk_i); ts_n = 1;
        do begin s |= !sel_n; @(negedge mclk_i); n++; end while (busy !== 1'b0 && n < 60);
    endtask
    task automatic t_boot;
        int n; logic s;
        go(32'h0000_0004, n, s); chk(n, 8); chk(ack_n, 0);
        chk(oe, 1);
        chk(fa, 32'h7FE0_0004);
        go(32'h4000_0000, n, s); chk(s, 1); chk(n, 8);
        $display("boot map done");
    endtask
    task automatic t_jump;
        int n; logic s;
        jp = 1; repeat (5) @(negedge mclk_i);
        go(32'h0000_0000, n, s); chk(fa, 32'h7FF0_0000);
        jp = 0; repeat (5) @(negedge mclk_i);
        $display("jumper done");
    endtask
    task automatic t_map;
        int n; logic s;
        @(negedge mclk_i); mw = 1; @(negedge mclk_i); mw = 0;
        go(32'h7FE0_0010, n, s); chk(n, 8); chk(fa, 32'h7FE0_0010);
        on = 1; wt = 4'h3;
        go(32'h4000_0000, n, s); chk(s, 0); chk(n, 10);
        chk(ack_n, 1);
        on = 0;
        $display("relocation done");
    endtask
    task automatic t_cfg;
        @(negedge mclk_i); cw = 1; cd = 4'hA; @(negedge mclk_i); cw = 0; @(negedge mclk_i);
        chk(cb, 4'hA); chk(led, 4'h5);
        $display("helper mux done");
    endtask
    task test_done;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge mclk_i) if (++cyc_n == 5000) begin err_total++; test_done; end
    initial begin
        repeat (2) @(negedge mclk_i); reset_n_i = 1;
        t_boot; t_jump; t_map; t_cfg; test_done;
    end
endmodule // tb_bmb_boot_map
